//--- hdl/mmac_pkg.sv
// What this block does
// - segments hold rights, bounds, relocation, 64
// - segments carry hardware register rights too
// - segment without rights is disabled
// - any segment count up to 64
// - six firewall registers plus exchange window
// - check permission before memory access
// - check every mode and operation
// - each register gated by cpu mode
// - user/contactless modes use segment, firewall
// - denied register read returns zero
// - denied register write is dropped
// - variant reserves 128 nonvolatile bytes
// - five modes from status word plus bits
// - system mode reads/writes application ram, no ram execute
package mmac_pkg;
   localparam int NSEG = 64;
   localparam int SEG_W = 6;
   localparam int ADDR_W = 16;
   localparam int SFR_AW = 7;
   localparam int HW_W = 16;
   localparam int ADDR_PHYS_W = 16;
   localparam logic [1:0] SPACE_ROM = 2'h0;
   localparam logic [1:0] SPACE_NVM = 2'h1;
   localparam logic [1:0] SPACE_RAM = 2'h2;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_EXEC = 2'h2;
   localparam logic [15:0] MFR_RSV_BYTES = 16'h0080;
   localparam logic [15:0] NVM_TOP = 16'hffff;
   localparam logic [15:0] MFR_RSV_BASE = 16'hff80;
   // register space classes
   localparam logic [6:0] SFR_HW_FIRST = 7'h40;
   localparam logic [6:0] SFR_HW_LAST = 7'h4f;
   localparam logic [6:0] SFR_SYS_FIRST = 7'h50;
   localparam logic [6:0] SFR_SYS_LAST = 7'h5f;
   localparam logic [6:0] SFR_FW_FIRST = 7'h60;
   localparam logic [6:0] SFR_FW_LAST = 7'h65;
   localparam logic [6:0] SFR_TEST_FIRST = 7'h70;
   localparam logic [6:0] SFR_TEST_LAST = 7'h7f;
   localparam logic [7:0] FW_RESET = 8'h00;
   localparam int STAT_BOOT_BIT = 1;
   localparam int STAT_TEST_BIT = 0;
   localparam int STAT_SYS_BIT = 7;
   localparam int STAT_CL_BIT = 6;

   typedef enum logic [2:0] {
      MODE_BOOT, MODE_TEST, MODE_CONTACTLESS, MODE_SYSTEM, MODE_USER
   } mmac_mode_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic ex;
      logic [HW_W-1:0] hw_rd;
      logic [HW_W-1:0] hw_wr;
      logic [ADDR_W-1:0] first;
      logic [ADDR_W-1:0] last;
      logic [ADDR_PHYS_W-1:0] reloc;
   } mmac_seg_s;

   typedef struct packed {
      logic valid;
      logic [1:0] op;
      logic [1:0] space;
      logic [ADDR_W-1:0] vaddr;
   } mmac_mreq_s;

   typedef struct packed {
      logic valid;
      logic wr;
      logic [SFR_AW-1:0] addr;
      logic [7:0] wdata;
   } mmac_sreq_s;
endpackage

//--- hdl/mmac_seg_match.sv
`timescale 1ns/1ps
module mmac_seg_match (
   input wire mmac_pkg::mmac_seg_s seg_i [mmac_pkg::NSEG],
   input wire logic [mmac_pkg::ADDR_W-1:0] vaddr_i,
   output logic hit_o,
   output logic [mmac_pkg::SEG_W-1:0] idx_o
);
   import mmac_pkg::*;
   // ------------------------------------------------
   // lowest matching enabled segment wins
   // ------------------------------------------------
   always_comb begin
      hit_o = 1'b0;
      idx_o = '0;
      for (int i = NSEG - 1; i >= 0; i--) begin
         if ((seg_i[i].rd | seg_i[i].wr | seg_i[i].ex) &&
             vaddr_i >= seg_i[i].first && vaddr_i <= seg_i[i].last) begin
            hit_o = 1'b1;
            idx_o = SEG_W'(i);
         end
      end
   end
endmodule

//--- hdl/mmac_top.sv
`timescale 1ns/1ps
module mmac_top (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] status_word_high_i,
   input wire logic [1:0] mode_bits_i,
   input wire logic contactless_en_i,
   input wire logic seg_we_i,
   input wire logic [mmac_pkg::SEG_W-1:0] seg_widx_i,
   input wire mmac_pkg::mmac_seg_s seg_wdata_i,
   input wire logic [mmac_pkg::SEG_W-1:0] code_seg_i,
   input wire mmac_pkg::mmac_mreq_s mreq_i,
   input wire mmac_pkg::mmac_sreq_s sreq_i,
   input wire logic [7:0] sfr_rdata_i,
   output logic mem_valid_o,
   output logic [1:0] mem_op_o,
   output logic [1:0] mem_space_o,
   output logic [mmac_pkg::ADDR_PHYS_W-1:0] mem_paddr_o,
   output logic mem_violation_o,
   output logic sfr_wr_o,
   output logic [mmac_pkg::SFR_AW-1:0] sfr_addr_o,
   output logic [7:0] sfr_wdata_o,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_violation_o,
   output logic [2:0] mode_o
);
   import mmac_pkg::*;

   function automatic logic in_rng(input logic [SFR_AW-1:0] a, input logic [SFR_AW-1:0] lo,
                                   input logic [SFR_AW-1:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   // ------------------------------------------------
   // segment table
   // ------------------------------------------------
   mmac_seg_s seg_q [NSEG];
   mmac_seg_s seg_d [NSEG];

   always_comb begin
      seg_d = seg_q;
      if (seg_we_i) begin
         seg_d[seg_widx_i] = seg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NSEG; i++) begin
            seg_q[i] <= '0;
         end
      end else begin
         seg_q <= seg_d;
      end
   end

   // ------------------------------------------------
   // cpu mode
   // ------------------------------------------------
   mmac_mode_e mode;
   always_comb begin
      if (mode_bits_i[STAT_BOOT_BIT]) begin
         mode = MODE_BOOT;
      end else if (mode_bits_i[STAT_TEST_BIT]) begin
         mode = MODE_TEST;
      end else if (!status_word_high_i[STAT_SYS_BIT]) begin
         mode = MODE_USER;
      end else if (status_word_high_i[STAT_CL_BIT] && contactless_en_i) begin
         mode = MODE_CONTACTLESS;
      end else begin
         mode = MODE_SYSTEM;
      end
   end

   // ------------------------------------------------
   // firewall registers, written through the register path
   // ------------------------------------------------
   logic [7:0] fw_q [6];
   logic [7:0] fw_d [6];
   logic sfr_grant_wr;
   logic sfr_grant_rd;
   logic [2:0] fw_idx;
   assign fw_idx = 3'(sreq_i.addr - SFR_FW_FIRST);

   always_comb begin
      fw_d = fw_q;
      if (sreq_i.valid && sreq_i.wr && sfr_grant_wr && in_rng(sreq_i.addr, SFR_FW_FIRST, SFR_FW_LAST)) begin
         fw_d[fw_idx] = sreq_i.wdata;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 6; i++) begin
            fw_q[i] <= FW_RESET;
         end
      end else begin
         fw_q <= fw_d;
      end
   end

   // 0,1 firewall control; 2,3 window base; 4,5 window size
   logic [15:0] fw_ctrl;
   logic [15:0] xwin_base;
   logic [15:0] xwin_size;
   assign fw_ctrl = {fw_q[1], fw_q[0]};
   assign xwin_base = {fw_q[3], fw_q[2]};
   assign xwin_size = {fw_q[5], fw_q[4]};

   // ------------------------------------------------
   // memory translation and check
   // ------------------------------------------------
   logic hit;
   logic [SEG_W-1:0] hidx;
   mmac_seg_s hseg;

   mmac_seg_match u_match (
      .seg_i(seg_q),
      .vaddr_i(mreq_i.vaddr),
      .hit_o(hit),
      .idx_o(hidx)
   );
   assign hseg = seg_q[hidx];

   logic mem_ok;
   logic [ADDR_PHYS_W-1:0] paddr;
   logic in_xwin;
   logic [16:0] xwin_end;
   assign xwin_end = {1'b0, xwin_base} + {1'b0, xwin_size};
   assign in_xwin = (mreq_i.vaddr >= xwin_base) && ({1'b0, mreq_i.vaddr} < xwin_end);

   always_comb begin
      mem_ok = 1'b0;
      paddr = mreq_i.vaddr;
      unique case (mode)
         MODE_BOOT, MODE_TEST: begin
            mem_ok = !(mreq_i.op == OP_EXEC && mreq_i.space == SPACE_RAM) &&
                     !(mreq_i.op == OP_WRITE && mreq_i.space == SPACE_ROM);
         end
         MODE_CONTACTLESS: begin
            mem_ok = (mreq_i.space != SPACE_RAM) ? (mreq_i.op != OP_WRITE || mreq_i.space == SPACE_NVM)
                                                 : (mreq_i.op != OP_EXEC && in_xwin);
         end
         MODE_SYSTEM: begin
            mem_ok = !(mreq_i.op == OP_EXEC && mreq_i.space == SPACE_RAM) &&
                     !(mreq_i.op == OP_WRITE && mreq_i.space == SPACE_ROM);
         end
         MODE_USER: begin
            paddr = ADDR_PHYS_W'(mreq_i.vaddr + hseg.reloc);
            unique case (mreq_i.op)
               OP_READ: mem_ok = hit && hseg.rd;
               OP_WRITE: mem_ok = hit && hseg.wr && mreq_i.space != SPACE_ROM;
               default: mem_ok = hit && hseg.ex && mreq_i.space != SPACE_RAM;
            endcase
         end
         default: mem_ok = 1'b0;
      endcase
      if (!contactless_en_i && mode != MODE_TEST && mode != MODE_BOOT && mreq_i.space == SPACE_NVM &&
          paddr >= MFR_RSV_BASE) begin
         mem_ok = 1'b0;
      end
   end

   logic mem_valid_d;
   logic mem_viol_d;
   assign mem_valid_d = mreq_i.valid && mem_ok;
   assign mem_viol_d = mreq_i.valid && !mem_ok;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_valid_o <= 1'b0;
         mem_op_o <= OP_READ;
         mem_space_o <= SPACE_ROM;
         mem_paddr_o <= '0;
         mem_violation_o <= 1'b0;
      end else begin
         mem_valid_o <= mem_valid_d;
         mem_op_o <= mreq_i.op;
         mem_space_o <= mreq_i.space;
         mem_paddr_o <= mem_valid_d ? paddr : '0;
         mem_violation_o <= mem_viol_d;
      end
   end

   // ------------------------------------------------
   // register access gate
   // ------------------------------------------------
   logic is_hw;
   logic [3:0] hw_bit;
   mmac_seg_s cseg;
   assign is_hw = in_rng(sreq_i.addr, SFR_HW_FIRST, SFR_HW_LAST);
   assign hw_bit = 4'(sreq_i.addr - SFR_HW_FIRST);
   assign cseg = seg_q[code_seg_i];

   always_comb begin
      sfr_grant_rd = 1'b0;
      sfr_grant_wr = 1'b0;
      unique case (mode)
         MODE_BOOT, MODE_TEST: begin
            sfr_grant_rd = 1'b1;
            sfr_grant_wr = 1'b1;
         end
         MODE_SYSTEM: begin
            sfr_grant_rd = !in_rng(sreq_i.addr, SFR_TEST_FIRST, SFR_TEST_LAST);
            sfr_grant_wr = sfr_grant_rd;
         end
         MODE_USER: begin
            sfr_grant_rd = is_hw ? (cseg.hw_rd[hw_bit] && (cseg.rd | cseg.wr | cseg.ex))
                                 : !in_rng(sreq_i.addr, SFR_SYS_FIRST, SFR_TEST_LAST);
            sfr_grant_wr = is_hw ? (cseg.hw_wr[hw_bit] && (cseg.rd | cseg.wr | cseg.ex))
                                 : !in_rng(sreq_i.addr, SFR_SYS_FIRST, SFR_TEST_LAST);
         end
         MODE_CONTACTLESS: begin
            sfr_grant_rd = is_hw ? fw_ctrl[hw_bit] : !in_rng(sreq_i.addr, SFR_SYS_FIRST, SFR_TEST_LAST);
            sfr_grant_wr = sfr_grant_rd;
         end
         default: begin
            sfr_grant_rd = 1'b0;
            sfr_grant_wr = 1'b0;
         end
      endcase
   end

   logic sfr_ok;
   assign sfr_ok = sreq_i.wr ? sfr_grant_wr : sfr_grant_rd;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sfr_wr_o <= 1'b0;
         sfr_addr_o <= '0;
         sfr_wdata_o <= 8'h00;
         sfr_rdata_o <= 8'h00;
         sfr_violation_o <= 1'b0;
         mode_o <= 3'h0;
      end else begin
         sfr_wr_o <= sreq_i.valid && sreq_i.wr && sfr_grant_wr;
         sfr_addr_o <= sreq_i.addr;
         sfr_wdata_o <= sreq_i.wdata;
         sfr_rdata_o <= (sreq_i.valid && !sreq_i.wr && sfr_grant_rd) ? sfr_rdata_i : 8'h00;
         sfr_violation_o <= sreq_i.valid && !sfr_ok;
         mode_o <= 3'(mode);
      end
   end
endmodule

//--- testbench/mmac_top_monitor.sv
`timescale 1ns/1ps
module mmac_top_monitor (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [1:0] mode_bits_i,
   input wire mmac_pkg::mmac_mreq_s mreq_i,
   input wire mmac_pkg::mmac_sreq_s sreq_i,
   input wire logic mem_valid_o,
   input wire logic [1:0] mem_op_o,
   input wire logic [mmac_pkg::ADDR_PHYS_W-1:0] mem_paddr_o,
   input wire logic mem_violation_o,
   input wire logic sfr_wr_o,
   input wire logic [7:0] sfr_wdata_o,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic sfr_violation_o,
   input wire logic [2:0] mode_o
);
   import mmac_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // -----------------
   // access checks
   // -----------------
   a_mem_one_answer: assert property (mreq_i.valid |=> mem_valid_o ^ mem_violation_o)
      else $error("memory request got no single answer");
   a_mem_quiet_idle: assert property (!mreq_i.valid |=> !mem_valid_o && !mem_violation_o)
      else $error("memory output without request");
   a_denied_no_addr: assert property (mem_violation_o |-> mem_paddr_o == 16'h0000)
      else $error("blocked access leaked an address");
   a_mem_op_echo: assert property (mreq_i.valid ##1 mem_valid_o |-> mem_op_o == $past(mreq_i.op))
      else $error("granted op differs from request");
   a_sfr_read_zero: assert property ((sreq_i.valid && !sreq_i.wr) ##1 sfr_violation_o |-> sfr_rdata_o == 8'h00)
      else $error("denied read returned data");
   a_sfr_wr_drop: assert property (sfr_violation_o |-> !sfr_wr_o)
      else $error("denied write reached register file");
   a_sfr_wr_gate: assert property (sreq_i.valid |=> sfr_violation_o || sfr_wr_o == $past(sreq_i.wr))
      else $error("register access neither granted nor denied");
   a_sfr_wr_data: assert property (sreq_i.valid && sreq_i.wr ##1 sfr_wr_o |-> sfr_wdata_o == $past(sreq_i.wdata))
      else $error("written data altered");
   a_boot_mode: assert property (mode_bits_i[1] ##1 mode_bits_i[1] |-> mode_o == 3'h0)
      else $error("boot bit not decoded");
   c_mem_deny: cover property (mreq_i.valid ##1 mem_violation_o);
   c_sfr_deny: cover property (sreq_i.valid ##1 sfr_violation_o);
   c_sfr_write: cover property (sfr_wr_o);
endmodule

bind mmac_top mmac_top_monitor u_mmac_top_monitor (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .mode_bits_i(mode_bits_i), .mreq_i(mreq_i), .sreq_i(sreq_i), .mem_valid_o(mem_valid_o),
   .mem_op_o(mem_op_o), .mem_paddr_o(mem_paddr_o), .mem_violation_o(mem_violation_o), .sfr_wr_o(sfr_wr_o),
   .sfr_wdata_o(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_o), .sfr_violation_o(sfr_violation_o), .mode_o(mode_o));

//--- testbench/mmac_cpu_model.sv
`timescale 1ns/1ps
module mmac_cpu_model (
   input wire logic clk_sys_i,
   output mmac_pkg::mmac_mreq_s mreq_o,
   output mmac_pkg::mmac_sreq_s sreq_o
);
   import mmac_pkg::*;
   initial begin
      mreq_o = '0;
      sreq_o = '0;
   end
   task automatic mem(input logic [1:0] op, input logic [1:0] sp, input logic [15:0] va);
      @(posedge clk_sys_i);
      mreq_o <= {1'b1, op, sp, va};
      @(posedge clk_sys_i);
      // released lines show garbage, never the last address
      mreq_o <= {1'b0, ~op, ~sp, ~va};
   endtask
   task automatic special_function_register(input logic wr, input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      sreq_o <= {1'b1, wr, a, d};
      @(posedge clk_sys_i);
      sreq_o <= {1'b0, ~wr, ~a, ~d};
   endtask
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import mmac_pkg::*;
   logic clk_sys_i, rst_n_i, ce, we, m_v, m_x, s_w, s_x;
   logic [7:0] swh, s_rd, r, sfr_rdata_i;
   logic [1:0] mb, m_op, m_sp;
   logic [5:0] widx, cseg;
   logic [15:0] pa;
   logic [2:0] mode;
   logic [6:0] s_a;
   logic [7:0] s_wd;
   mmac_seg_s wd;
   mmac_mreq_s mreq;
   mmac_sreq_s sreq;
   int miscompares, checked, cyc, i;
   mmac_top u_mmac_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .status_word_high_i(swh), .mode_bits_i(mb),
      .contactless_en_i(ce), .seg_we_i(we), .seg_widx_i(widx), .seg_wdata_i(wd), .code_seg_i(cseg),
      .mreq_i(mreq), .sreq_i(sreq), .sfr_rdata_i(sfr_rdata_i), .mem_valid_o(m_v), .mem_op_o(m_op),
      .mem_space_o(m_sp), .mem_paddr_o(pa), .mem_violation_o(m_x), .sfr_wr_o(s_w), .sfr_addr_o(s_a),
      .sfr_wdata_o(s_wd), .sfr_rdata_o(s_rd), .sfr_violation_o(s_x), .mode_o(mode));
   mmac_cpu_model u_mmac_cpu_model (.clk_sys_i(clk_sys_i), .mreq_o(mreq), .sreq_o(sreq));
   // register file answers with a value that is never zero
   assign sfr_rdata_i = {1'b1, sreq.addr};
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [7:0] lf(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // memory request, then compare grant, violation and physical address
   task automatic mt(input logic [1:0] op, sp, input logic [15:0] va, input logic ok, input logic [15:0] ep);
      u_mmac_cpu_model.mem(op, sp, va);
      #1 chk({m_v, m_x, pa}, {ok, !ok, ok ? ep : 16'h0000});
      chk({m_op, m_sp}, {op, sp});
   endtask
   task automatic st(input logic wr, input logic [6:0] a, input logic [7:0] d, input logic ok);
      u_mmac_cpu_model.special_function_register(wr, a, d);
      #1 chk({s_x, s_w, s_rd}, {!ok, wr & ok, (ok & !wr) ? {1'b1, a} : 8'h00});
      chk({s_a, s_wd}, {a, d});
   endtask
   task automatic setm(input logic [7:0] s, input logic [1:0] b, input logic c);
      @(posedge clk_sys_i) {swh, mb, ce} <= {s, b, c};
      repeat (2) @(posedge clk_sys_i);
   endtask
   task automatic wseg(input logic [5:0] ix, input mmac_seg_s s);
      @(posedge clk_sys_i) {we, widx, wd} <= {1'b1, ix, s};
      @(posedge clk_sys_i) we <= 1'b0;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      {rst_n_i, swh, mb, ce, we, widx, wd, cseg} = '0;
      r = 8'd34;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      #1 chk({m_v, m_x, s_x, s_w}, 4'h0);
      // walk all five modes
      for (i = 0; i < 5; i++) begin
         setm(i == 2 ? 8'hc0 : i == 3 ? 8'h80 : 8'h00, i == 0 ? 2'b10 : i == 1 ? 2'b01 : 2'b00, 1'b1);
         #1 chk(mode, i[2:0]);
      end
      wseg(6'd2, {3'b000, 16'hffff, 16'hffff, 16'h1000, 16'h1fff, 16'h0000});
      wseg(6'd5, {3'b100, 16'h0008, 16'h0000, 16'h1000, 16'h1fff, 16'h2000});
      wseg(6'd63, {3'b100, 16'h0000, 16'h0000, 16'h4000, 16'h40ff, 16'h0000});
      @(posedge clk_sys_i) cseg <= 6'd5;
      mt(OP_READ, SPACE_RAM, 16'h1000, 1'b1, 16'h3000);
      mt(OP_READ, SPACE_RAM, 16'h1fff, 1'b1, 16'h3fff);
      mt(OP_READ, SPACE_RAM, 16'h2000, 1'b0, 16'h0000);
      mt(OP_WRITE, SPACE_RAM, 16'h1800, 1'b0, 16'h0000);
      mt(OP_EXEC, SPACE_ROM, 16'h1800, 1'b0, 16'h0000);
      mt(OP_READ, SPACE_RAM, 16'h4000, 1'b1, 16'h4000);
      for (i = 0; i < 8; i++) begin
         r = lf(r);
         mt(OP_READ, SPACE_RAM, {4'h1, r, r[3:0]}, 1'b1, {4'h1, r, r[3:0]} + 16'h2000);
      end
      st(1'b0, 7'h43, 8'h00, 1'b1);
      st(1'b0, 7'h44, 8'h00, 1'b0);
      st(1'b1, 7'h43, 8'h55, 1'b0);
      st(1'b0, 7'h50, 8'h00, 1'b0);
      @(posedge clk_sys_i) cseg <= 6'd2;
      st(1'b0, 7'h43, 8'h00, 1'b0);
      setm(8'h80, 2'b00, 1'b1);
      mt(OP_READ, SPACE_RAM, 16'h1234, 1'b1, 16'h1234);
      mt(OP_WRITE, SPACE_RAM, 16'h1234, 1'b1, 16'h1234);
      mt(OP_EXEC, SPACE_RAM, 16'h1234, 1'b0, 16'h0000);
      st(1'b0, 7'h70, 8'h00, 1'b0);
      st(1'b0, 7'h50, 8'h00, 1'b1);
      // firewall: hw register 0x40 only, window 0x3000 size 0x10
      for (i = 0; i < 6; i++) begin
         st(1'b1, 7'h60 + i[6:0], i == 0 ? 8'h01 : i == 3 ? 8'h30 : i == 4 ? 8'h10 : 8'h00, 1'b1);
      end
      // contactless mode needs the system bit as well as its own bit
      setm(8'hc0, 2'b00, 1'b1);
      st(1'b0, 7'h40, 8'h00, 1'b1);
      st(1'b0, 7'h41, 8'h00, 1'b0);
      mt(OP_READ, SPACE_RAM, 16'h300f, 1'b1, 16'h300f);
      mt(OP_READ, SPACE_RAM, 16'h3010, 1'b0, 16'h0000);
      setm(8'h80, 2'b00, 1'b0);
      mt(OP_READ, SPACE_NVM, 16'hff80, 1'b0, 16'h0000);
      mt(OP_READ, SPACE_NVM, 16'hff7f, 1'b1, 16'hff7f);
      give_verdict();
   end
endmodule
